// file: logic/out_ctrl_pkg.sv
package out_ctrl_pkg;
   localparam int NSW = 6;
   localparam int NPO = 8;
   localparam int NCH = NSW + NPO;
   localparam int CUR_W = 13;
   localparam int DUTY_W = 12;
   localparam int PER_W = 20;
   localparam int HOLD_W = 23;
   localparam int CLK_HZ = 25_000_000;
   // hold time after a switch opens or an overcurrent trip, in ms
   localparam int HOLD_MS = 250;
   localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
   localparam int PWM_HZ_MIN = 33;
   localparam int PWM_HZ_MAX = 4000;
   localparam logic [PER_W-1:0] PER_MAX = PER_W'(CLK_HZ / PWM_HZ_MIN);
   localparam logic [PER_W-1:0] PER_MIN = PER_W'((CLK_HZ + PWM_HZ_MAX - 1) / PWM_HZ_MAX);
   // currents in mA, one count per mA
   localparam logic [CUR_W-1:0] SW_OPEN_MA = 13'h00DC;
   localparam logic [CUR_W-1:0] SW_MAX_MA = 13'h0BB8;
   localparam logic [15:0] SINK_MAX_MA = 16'h1F40;
   localparam logic [CUR_W-1:0] IMAX_RST = 13'h1388;
   localparam logic [DUTY_W-1:0] CL_STEP = 12'h004;
   localparam logic [7:0] DITH_DIV_RST = 8'h01;
   localparam logic [7:0] SW_CMD_OFS = 8'h00;
   localparam logic [7:0] SW_PAR_OFS = 8'h04;
   localparam logic [7:0] SW_STAT_OFS = 8'h08;
   localparam logic [7:0] FLT_CLR_OFS = 8'h0C;
   localparam logic [7:0] FB_OFS = 8'h10;
   localparam logic [7:0] PO_STAT_OFS = 8'h14;
   localparam logic [7:0] IMAX_OFS = 8'h18;
   localparam logic [7:0] DITH_OFS = 8'h1C;
   localparam logic [7:0] PO_CMD_OFS = 8'h20;
   localparam logic [7:0] PO_CFG_OFS = 8'h40;
   localparam logic [7:0] PO_PER_OFS = 8'h60;
   localparam int STAT_OPEN_POS = 8;
   localparam int STAT_SHORT_POS = 16;
   localparam int FB_RED_POS = 16;
   localparam int PO_SHORT_POS = 8;
   localparam int PO_OC_POS = 16;
   localparam int PO_HOLD_POS = 24;
   localparam int DITH_DIV_POS = 16;
   localparam int CFG_W = 6;
   localparam int CFG_CL = 0;
   localparam int CFG_LOW = 1;
   localparam int CFG_DITH = 2;
   localparam int CFG_DUAL = 3;
   localparam int CFG_DIG = 4;
   localparam int CFG_SINK = 5;
endpackage

// file: logic/hold_timer.sv
module hold_timer #(
   parameter int CYCLES = out_ctrl_pkg::HOLD_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   output logic busy
);
   import out_ctrl_pkg::*;
   logic [HOLD_W-1:0] cnt_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else if (start) begin
         cnt_r <= HOLD_W'(CYCLES);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign busy = (cnt_r != '0);
endmodule

// file: logic/pwm_gen.sv
module pwm_gen (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [out_ctrl_pkg::PER_W-1:0] period,
   input wire logic [out_ctrl_pkg::DUTY_W-1:0] duty,
   output logic out,
   output logic wrap
);
   import out_ctrl_pkg::*;
   logic [PER_W-1:0] cnt_r;
   logic [PER_W-1:0] on_r;
   logic [31:0] prod;

   // on time is period * duty / 2^DUTY_W, taken only at a period boundary
   assign prod = 32'(period) * 32'(duty);
   assign wrap = (cnt_r >= period - 1'b1);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
         on_r <= '0;
      end else if (wrap) begin
         cnt_r <= '0;
         on_r <= prod[PER_W+DUTY_W-1:DUTY_W];
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out <= 1'b0;
      end else begin
         out <= (cnt_r < on_r);
      end
   end
endmodule

// file: logic/out_ctrl.sv
// Functional notes
// - each channel conducts only when primary and redundant series switches are closed; sink-mode proportional outputs conduct via low_en alone
// - redundant switch feedback is returned to the secondary controller
// - secondary controller may open any redundant switch at any time
// - reopened redundant switch is held open 250 ms before closing again
// - with redundant switch closed, switched outputs follow the primary command
// - primary switch feedback is readable by the primary processor
// - switched output flags open load below 0.22 A, OK only 0.22 to 3 A
// - switched output short: limit, flag, off while short, resume when cleared
// - paralleled switched outputs switch together, keeping per-channel diagnostics
// - switched outputs off by command; watchdog forces them off
// - proportional output runs open-loop duty or closed-loop current
// - pwm period is software set; optional dither on top of command
// - open loop applies duty as voltage; total sinking current limited to 8 A
// - closed-loop overcurrent shuts output down and latches it off
// - output not re-energized within 250 ms of overcurrent shutdown
// - latch clears only after command returns to zero or false
// - dual-coil regulation compensates current induced in the non-driven coil
// - mode and full-scale current range set by configuration
// - proportional output short is reported and output protected
// - pwm frequency clamped to 33 to 4000 Hz
module out_ctrl #(
   parameter int HOLD_CYCLES = out_ctrl_pkg::HOLD_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [out_ctrl_pkg::NCH-1:0] sec_close,
   input wire logic [out_ctrl_pkg::NCH-1:0] red_fb,
   input wire logic [out_ctrl_pkg::NCH-1:0] prim_fb,
   input wire logic [out_ctrl_pkg::NSW-1:0] sw_short,
   input wire logic [out_ctrl_pkg::NPO-1:0] po_short,
   input wire logic wdog_trip,
   input wire logic [out_ctrl_pkg::NSW*out_ctrl_pkg::CUR_W-1:0] sw_cur,
   input wire logic [out_ctrl_pkg::NPO*out_ctrl_pkg::CUR_W-1:0] po_cur,
   output logic [out_ctrl_pkg::NCH-1:0] prim_en,
   output logic [out_ctrl_pkg::NCH-1:0] red_en,
   output logic [out_ctrl_pkg::NCH-1:0] sec_fb,
   output logic [out_ctrl_pkg::NSW-1:0] cur_limit,
   output logic [out_ctrl_pkg::NPO-1:0] low_en
);
   import out_ctrl_pkg::*;
   localparam int NPIN = 3 * NCH + NSW + NPO + 1;

   logic [NPIN-1:0] pin_s1_r;
   logic [NPIN-1:0] pin_s2_r;
   logic [NCH-1:0] sec_s;
   logic [NCH-1:0] red_fb_s;
   logic [NCH-1:0] prim_fb_s;
   logic [NSW-1:0] sw_short_s;
   logic [NPO-1:0] po_short_s;
   logic wdog_s;

   logic ack_r;
   logic [31:0] rdat_r;
   logic [31:0] rd;
   logic wr;
   logic [NSW-1:0] sw_cmd_r;
   logic [NSW-1:0] sw_par_r;
   logic [DUTY_W-1:0] po_cmd_r [NPO];
   logic [CFG_W-1:0] po_cfg_r [NPO];
   logic [PER_W-1:0] po_per_r [NPO];
   logic [CUR_W-1:0] imax_r;
   logic [DUTY_W-1:0] dith_amp_r;
   logic [7:0] dith_div_r;
   logic [31:0] clr;

   logic [NSW-1:0] sw_drv;
   logic [NSW-1:0] sw_ok_r;
   logic [NSW-1:0] sw_open_r;
   logic [NSW-1:0] sw_sf_r;
   logic [NPO-1:0] po_hi;
   logic [NPO-1:0] po_lo;
   logic [NPO-1:0] po_latch;
   logic [NPO-1:0] po_hold;
   logic [NPO-1:0] po_trip;
   logic [NPO-1:0] po_sf_r;
   logic [NPO-1:0] po_oc_r;
   logic [NPO-1:0] po_sink_on;
   logic [NCH-1:0] red_busy;
   logic [NCH-1:0] prim_en_r;
   logic [NCH-1:0] red_en_r;
   logic [NSW-1:0] cur_limit_r;
   logic [NPO-1:0] low_en_r;
   logic [15:0] sink_sum;
   logic sink_over_r;

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
      logic [31:0] m;
      for (int b = 0; b < 4; b++) begin
         m[8*b +: 8] = {8{s[b]}};
      end
      return (o & ~m) | (d & m);
   endfunction

   // two-stage synchroniser for every pin input except the sw_cur and po_cur buses
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= {wdog_trip, po_short, sw_short, prim_fb, red_fb, sec_close};
         pin_s2_r <= pin_s1_r;
      end
   end

   assign {wdog_s, po_short_s, sw_short_s, prim_fb_s, red_fb_s, sec_s} = pin_s2_r;

   // wishbone slave: ack one cycle after the request, writes land at the ack edge
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_r <= 1'b0;
         rdat_r <= '0;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
         if (wb_cyc_i & wb_stb_i & ~ack_r & ~wb_we_i) begin
            rdat_r <= rd;
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   always_comb begin
      rd = '0;
      if (wb_adr_i == SW_CMD_OFS) begin
         rd[NSW-1:0] = sw_cmd_r;
      end else if (wb_adr_i == SW_PAR_OFS) begin
         rd[NSW-1:0] = sw_par_r;
      end else if (wb_adr_i == SW_STAT_OFS) begin
         rd[NSW-1:0] = sw_ok_r;
         rd[STAT_OPEN_POS +: NSW] = sw_open_r;
         rd[STAT_SHORT_POS +: NSW] = sw_sf_r;
      end else if (wb_adr_i == FB_OFS) begin
         rd[NCH-1:0] = prim_fb_s;
         rd[FB_RED_POS +: NCH] = red_fb_s;
      end else if (wb_adr_i == PO_STAT_OFS) begin
         rd[NPO-1:0] = po_latch;
         rd[PO_SHORT_POS +: NPO] = po_sf_r;
         rd[PO_OC_POS +: NPO] = po_oc_r;
         rd[PO_HOLD_POS +: NPO] = po_hold;
      end else if (wb_adr_i == IMAX_OFS) begin
         rd[CUR_W-1:0] = imax_r;
      end else if (wb_adr_i == DITH_OFS) begin
         rd[DUTY_W-1:0] = dith_amp_r;
         rd[DITH_DIV_POS +: 8] = dith_div_r;
      end
      for (int k = 0; k < NPO; k++) begin
         if (wb_adr_i == PO_CMD_OFS + 8'(4 * k)) begin
            rd[DUTY_W-1:0] = po_cmd_r[k];
         end
         if (wb_adr_i == PO_CFG_OFS + 8'(4 * k)) begin
            rd[CFG_W-1:0] = po_cfg_r[k];
         end
         if (wb_adr_i == PO_PER_OFS + 8'(4 * k)) begin
            rd[PER_W-1:0] = po_per_r[k];
         end
      end
   end

   // software registers; all commands zero after reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sw_cmd_r <= '0;
         sw_par_r <= '0;
         imax_r <= IMAX_RST;
         dith_amp_r <= '0;
         dith_div_r <= DITH_DIV_RST;
         for (int k = 0; k < NPO; k++) begin
            po_cmd_r[k] <= '0;
            po_cfg_r[k] <= '0;
            po_per_r[k] <= PER_MAX;
         end
      end else if (wr) begin
         if (wb_adr_i == SW_CMD_OFS) begin
            sw_cmd_r <= NSW'(wmerge(32'(sw_cmd_r), wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == SW_PAR_OFS) begin
            sw_par_r <= NSW'(wmerge(32'(sw_par_r), wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == IMAX_OFS) begin
            imax_r <= CUR_W'(wmerge(32'(imax_r), wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == DITH_OFS) begin
            dith_amp_r <= DUTY_W'(wmerge(32'(dith_amp_r), wb_dat_i, wb_sel_i));
            dith_div_r <= 8'(wmerge({8'h00, dith_div_r, 16'h0000}, wb_dat_i,
                                    wb_sel_i) >> DITH_DIV_POS);
         end
         for (int k = 0; k < NPO; k++) begin
            if (wb_adr_i == PO_CMD_OFS + 8'(4 * k)) begin
               po_cmd_r[k] <= DUTY_W'(wmerge(32'(po_cmd_r[k]), wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == PO_CFG_OFS + 8'(4 * k)) begin
               po_cfg_r[k] <= CFG_W'(wmerge(32'(po_cfg_r[k]), wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == PO_PER_OFS + 8'(4 * k)) begin
               po_per_r[k] <= PER_W'(wmerge(32'(po_per_r[k]), wb_dat_i, wb_sel_i));
            end
         end
      end
   end

   // write-one-to-clear fault flags; a new fault in the same cycle wins
   assign clr = (wr && wb_adr_i == FLT_CLR_OFS) ? wmerge('0, wb_dat_i, wb_sel_i) : '0;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sw_sf_r <= '0;
         po_sf_r <= '0;
         po_oc_r <= '0;
      end else begin
         sw_sf_r <= (sw_sf_r & ~clr[NSW-1:0]) | sw_short_s;
         po_sf_r <= (po_sf_r & ~clr[PO_SHORT_POS +: NPO]) | po_short_s;
         po_oc_r <= (po_oc_r & ~clr[PO_OC_POS +: NPO]) | po_trip;
      end
   end

   // switched outputs
   for (genvar i = 0; i < NSW; i++) begin : g_sw
      logic cmd_e;
      logic [CUR_W-1:0] cur;
      logic energ;
      assign cmd_e = sw_par_r[i] ? sw_cmd_r[0] : sw_cmd_r[i];
      assign cur = sw_cur[i*CUR_W +: CUR_W];
      assign energ = prim_en_r[i] & red_en_r[i];
      assign sw_drv[i] = cmd_e & ~wdog_s & ~sw_short_s[i];

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            sw_ok_r[i] <= 1'b0;
            sw_open_r[i] <= 1'b0;
         end else begin
            sw_ok_r[i] <= energ & (cur >= SW_OPEN_MA) & (cur <= SW_MAX_MA);
            sw_open_r[i] <= energ & (cur < SW_OPEN_MA);
         end
      end
   end

   // redundant switches, each with its own reclose hold-off
   for (genvar c = 0; c < NCH; c++) begin : g_red
      hold_timer #(.CYCLES(HOLD_CYCLES)) u_hold (
         .clk(clk),
         .nrst(nrst),
         .start(red_en_r[c] & ~sec_s[c]),
         .busy(red_busy[c])
      );
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         red_en_r <= '0;
         prim_en_r <= '0;
         cur_limit_r <= '0;
         low_en_r <= '0;
      end else begin
         red_en_r <= sec_s & ~red_busy;
         prim_en_r <= {po_hi, sw_drv};
         cur_limit_r <= sw_short_s;
         low_en_r <= po_lo;
      end
   end

   assign red_en = red_en_r;
   assign prim_en = prim_en_r;
   assign sec_fb = red_fb_s;
   assign cur_limit = cur_limit_r;
   assign low_en = low_en_r;

   // total sinking current of all proportional outputs
   always_comb begin
      sink_sum = '0;
      for (int k = 0; k < NPO; k++) begin
         if (po_sink_on[k]) begin
            sink_sum = sink_sum + 16'(po_cur[k*CUR_W +: CUR_W]);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sink_over_r <= 1'b0;
      end else begin
         sink_over_r <= (sink_sum > SINK_MAX_MA);
      end
   end

   // proportional outputs
   for (genvar k = 0; k < NPO; k++) begin : g_po
      logic [CFG_W-1:0] cfg;
      logic [CUR_W-1:0] cur;
      logic [CUR_W-1:0] pcur;
      logic [CUR_W-1:0] eff;
      logic [CUR_W-1:0] tgt;
      logic [PER_W-1:0] per;
      logic [DUTY_W-1:0] base;
      logic [DUTY_W-1:0] duty;
      logic [DUTY_W-1:0] cl_duty_r;
      logic [DUTY_W+1:0] dsum;
      logic [7:0] dcnt_r;
      logic dph_r;
      logic cmd_zero;
      logic latch_r;
      logic pwm;
      logic wrap;
      logic run;

      assign cfg = po_cfg_r[k];
      assign cur = po_cur[k*CUR_W +: CUR_W];
      assign pcur = po_cur[(k ^ 1)*CUR_W +: CUR_W];
      assign cmd_zero = (po_cmd_r[k] == '0);
      // induced current from the partner coil is removed before regulation
      assign eff = (cfg[CFG_DUAL] && cur > (pcur >> 1)) ? cur - (pcur >> 1) :
                   (cfg[CFG_DUAL] ? '0 : cur);
      assign tgt = cfg[CFG_LOW] ? CUR_W'(po_cmd_r[k] >> 2) : CUR_W'(po_cmd_r[k]);
      assign per = (po_per_r[k] < PER_MIN) ? PER_MIN :
                   (po_per_r[k] > PER_MAX) ? PER_MAX : po_per_r[k];
      assign base = cfg[CFG_DIG] ? (cmd_zero ? '0 : '1) :
                    cfg[CFG_CL] ? cl_duty_r : po_cmd_r[k];
      assign dsum = (cfg[CFG_DITH] & ~cfg[CFG_DIG]) ?
                    (dph_r ? {2'b00, base} + {2'b00, dith_amp_r} :
                     {2'b00, base} - {2'b00, dith_amp_r}) : {2'b00, base};
      assign duty = dsum[DUTY_W+1] ? '0 : (dsum[DUTY_W] ? '1 : dsum[DUTY_W-1:0]);
      assign po_trip[k] = (cfg[CFG_CL] & (cur > imax_r)) | po_short_s[k];
      assign run = ~latch_r & ~po_hold[k] & ~po_short_s[k];
      assign po_latch[k] = latch_r;
      assign po_hi[k] = pwm & run & ~cfg[CFG_SINK];
      assign po_lo[k] = pwm & run & cfg[CFG_SINK] & ~sink_over_r;
      assign po_sink_on[k] = cfg[CFG_SINK] & run;

      pwm_gen u_pwm (
         .clk(clk),
         .nrst(nrst),
         .period(per),
         .duty(duty),
         .out(pwm),
         .wrap(wrap)
      );

      hold_timer #(.CYCLES(HOLD_CYCLES)) u_oc_hold (
         .clk(clk),
         .nrst(nrst),
         .start(po_trip[k] & ~latch_r),
         .busy(po_hold[k])
      );

      // overcurrent latch: set on trip, released only by a zero command
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            latch_r <= 1'b0;
         end else if (po_trip[k]) begin
            latch_r <= 1'b1;
         end else if (cmd_zero) begin
            latch_r <= 1'b0;
         end
      end

      // closed-loop current regulation, one step per pwm period
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            cl_duty_r <= '0;
         end else if (~cfg[CFG_CL] | ~run) begin
            cl_duty_r <= '0;
         end else if (wrap) begin
            if (eff < tgt && cl_duty_r <= ~CL_STEP) begin
               cl_duty_r <= cl_duty_r + CL_STEP;
            end else if (eff > tgt && cl_duty_r >= CL_STEP) begin
               cl_duty_r <= cl_duty_r - CL_STEP;
            end
         end
      end

      // dither phase flips every dith_div pwm periods
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            dcnt_r <= '0;
            dph_r <= 1'b0;
         end else if (wrap) begin
            if (dcnt_r + 8'h01 >= dith_div_r) begin
               dcnt_r <= '0;
               dph_r <= ~dph_r;
            end else begin
               dcnt_r <= dcnt_r + 8'h01;
            end
         end
      end
   end
endmodule

// file: dv/out_ctrl_monitor.sv
module out_ctrl_monitor #(
   parameter int HOLD_CYCLES = out_ctrl_pkg::HOLD_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [out_ctrl_pkg::NCH-1:0] sec_close,
   input wire logic [out_ctrl_pkg::NCH-1:0] red_fb,
   input wire logic [out_ctrl_pkg::NCH-1:0] sec_fb,
   input wire logic [out_ctrl_pkg::NCH-1:0] prim_en,
   input wire logic [out_ctrl_pkg::NCH-1:0] red_en,
   input wire logic [out_ctrl_pkg::NSW-1:0] sw_short,
   input wire logic [out_ctrl_pkg::NPO-1:0] po_short,
   input wire logic [out_ctrl_pkg::NPO-1:0] low_en,
   input wire logic wdog_trip
);
   timeunit 1ns;
   timeprecision 1ns;
   import out_ctrl_pkg::*;
   logic [2:0] up_r;
   int hold_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // cycles since reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) up_r <= 3'h0;
      else if (up_r != 3'h7) up_r <= up_r + 3'h1;
   end
   // cycles since redundant switch 0 opened
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) hold_r <= HOLD_CYCLES;
      else if ($fell(red_en[0])) hold_r <= 1;
      else if (hold_r < HOLD_CYCLES) hold_r <= hold_r + 1;
   end
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_WB_ACK: assert property (req_s |=> ack_s) else $error("ack not a one cycle answer");
   AST_RST_ZERO: assert property (up_r < 3'h2 |-> prim_en == '0 && red_en == '0 && low_en == '0)
      else $error("outputs not off after reset");
   AST_SEC_FB: assert property (up_r > 3'h2 |-> sec_fb == $past(red_fb, 2))
      else $error("sec_fb not synced red_fb");
   AST_RED_OPEN: assert property (up_r > 3'h4 |->
      (red_en & ~($past(sec_close, 2) | $past(sec_close, 3) | $past(sec_close, 4))) == '0)
      else $error("red_en high without close request");
   AST_RED_HOLD: assert property ($rose(red_en[0]) |-> hold_r >= HOLD_CYCLES)
      else $error("red_en closed within hold");
   AST_WDOG: assert property (wdog_trip [*4] |-> prim_en[NSW-1:0] == '0)
      else $error("switched output on under watchdog");
   AST_SW_SHORT: assert property (up_r > 3'h4 |-> (prim_en[NSW-1:0] & $past(sw_short, 2)
      & $past(sw_short, 3) & $past(sw_short, 4)) == '0) else $error("shorted output on");
   AST_PO_SHORT: assert property (up_r > 3'h4 |-> ((prim_en[NCH-1:NSW] | low_en)
      & $past(po_short, 2) & $past(po_short, 3) & $past(po_short, 4)) == '0)
      else $error("shorted proportional on");
endmodule
bind out_ctrl out_ctrl_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) mon (.clk(clk), .nrst(nrst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sec_close(sec_close),
   .red_fb(red_fb), .sec_fb(sec_fb), .prim_en(prim_en), .red_en(red_en), .sw_short(sw_short),
   .po_short(po_short), .low_en(low_en), .wdog_trip(wdog_trip));

// file: dv/out_ctrl_partner.sv
module out_ctrl_partner (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [out_ctrl_pkg::NCH-1:0] prim_en,
   input wire logic [out_ctrl_pkg::NCH-1:0] red_en,
   input wire logic [out_ctrl_pkg::NPO-1:0] low_en,
   input wire logic [out_ctrl_pkg::NSW*out_ctrl_pkg::CUR_W-1:0] sw_ld,
   input wire logic [out_ctrl_pkg::NPO*out_ctrl_pkg::CUR_W-1:0] po_ld,
   output logic [out_ctrl_pkg::NCH-1:0] red_fb,
   output logic [out_ctrl_pkg::NCH-1:0] prim_fb,
   output logic [out_ctrl_pkg::NSW*out_ctrl_pkg::CUR_W-1:0] sw_cur,
   output logic [out_ctrl_pkg::NPO*out_ctrl_pkg::CUR_W-1:0] po_cur
);
   timeunit 1ns;
   timeprecision 1ns;
   import out_ctrl_pkg::*;
   // switch feedback follows the switch drive
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) red_fb <= '0;
      else red_fb <= red_en;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) prim_fb <= '0;
      else prim_fb <= prim_en;
   end
   // load current flows only through both series switches, or the low side
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) sw_cur <= '0;
      else for (int i = 0; i < NSW; i++) begin
         sw_cur[i*CUR_W+:CUR_W] <= (prim_en[i] & red_en[i]) ? sw_ld[i*CUR_W+:CUR_W] : '0;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) po_cur <= '0;
      else for (int k = 0; k < NPO; k++) begin
         po_cur[k*CUR_W+:CUR_W] <= ((prim_en[NSW+k] & red_en[NSW+k]) | low_en[k]) ?
            po_ld[k*CUR_W+:CUR_W] : '0;
      end
   end
endmodule

// file: dv/redundant_output_channel_control_test.sv
module redundant_output_channel_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   import out_ctrl_pkg::*;
   localparam int HC = 50;
   localparam int PM = int'(PER_MIN);
   logic clk, nrst, cyc, stb, we, ack, wdog, o, lv;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dw, dr, rd;
   logic [5:0] c, p;
   logic [NCH-1:0] sclose, red_fb, prim_fb, prim_en, red_en, sec_fb;
   logic [NSW-1:0] sw_short, cur_limit;
   logic [NPO-1:0] po_short, low_en;
   logic [NSW*CUR_W-1:0] sw_ld, sw_cur;
   logic [NPO*CUR_W-1:0] po_ld, po_cur;
   int n_mismatch, n_checks, seed, hi, nr;
   int ld[6] = '{0, 219, 220, 3000, 3001, 1500};
   out_ctrl #(.HOLD_CYCLES(HC)) dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
      .wb_ack_o(ack), .sec_close(sclose), .red_fb(red_fb), .prim_fb(prim_fb),
      .sw_short(sw_short), .po_short(po_short), .wdog_trip(wdog), .sw_cur(sw_cur),
      .po_cur(po_cur), .prim_en(prim_en), .red_en(red_en), .sec_fb(sec_fb),
      .cur_limit(cur_limit), .low_en(low_en));
   out_ctrl_partner far (.clk(clk), .nrst(nrst), .prim_en(prim_en), .red_en(red_en),
      .low_en(low_en), .sw_ld(sw_ld), .po_ld(po_ld), .red_fb(red_fb), .prim_fb(prim_fb),
      .sw_cur(sw_cur), .po_cur(po_cur));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #4000000;
      n_mismatch++;
      wrap_up();
   end
   task automatic wrap_up();
      if (n_mismatch == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
      int t;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      sel <= s;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 20);
      if (t >= 20) n_mismatch++;
      rd = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask
   // switched output model
   function automatic logic [5:0] sw_x(logic [5:0] cm, logic [5:0] pa);
      return (cm & ~pa) | (pa & {6{cm[0]}});
   endfunction
   initial begin
      seed = 32'h54F0AA96;
      {nrst, cyc, stb, we, wdog} = 5'h00;
      {adr, sel, dw, sclose, sw_short, po_short, sw_ld, po_ld} = '0;
      cy(2);
      nrst <= 1'b1;
      rdc(SW_CMD_OFS, "sw_cmd", 32'h0);
      rdc(PO_PER_OFS, "po_per", 32'(PER_MAX));
      rdc(IMAX_OFS, "imax", 32'(IMAX_RST));
      rdc(DITH_OFS, "dith", 32'(DITH_DIV_RST) << DITH_DIV_POS);
      rdc(8'hFC, "unmapped", 32'h0);
      sclose <= '1;
      cy(7);
      chk("red_en", 32'h3FFF, 32'(red_en));
      chk("sec_fb", 32'h3FFF, 32'(sec_fb));
      for (int i = 0; i < 8; i++) begin
         c = 6'($random(seed));
         p = (i > 3) ? 6'($random(seed)) : 6'h00;
         wr(SW_PAR_OFS, 32'(p));
         wr(SW_CMD_OFS, 32'(c));
         cy(5);
         chk("prim_en", 32'(sw_x(c, p)), 32'(prim_en));
         rdc(FB_OFS, "fb", 32'h3FFF0000 | 32'(sw_x(c, p)));
      end
      bus(1'b1, SW_CMD_OFS, 32'h3F, 4'h0);
      rdc(SW_CMD_OFS, "sw_cmd_sel", 32'(c));
      wr(SW_PAR_OFS, 32'h0);
      wr(SW_CMD_OFS, 32'h3F);
      for (int i = 0; i < 6; i++) sw_ld[i*CUR_W+:CUR_W] <= CUR_W'(ld[i]);
      cy(6);
      rdc(SW_STAT_OFS, "sw_stat", 32'h0000032C);
      wdog <= 1'b1;
      cy(5);
      chk("wdog", 32'h0, 32'(prim_en[5:0]));
      wdog <= 1'b0;
      sw_short <= 6'h04;
      cy(5);
      chk("short_off", 32'h3B, 32'(prim_en[5:0]));
      chk("cur_limit", 32'h04, 32'(cur_limit));
      bus(1'b0, SW_STAT_OFS, 32'h0);
      chk("short_flag", 32'h00040000, rd & 32'h00FF0000);
      sw_short <= 6'h00;
      cy(5);
      chk("resume", 32'h3F, 32'(prim_en[5:0]));
      wr(FLT_CLR_OFS, 32'h4);
      bus(1'b0, SW_STAT_OFS, 32'h0);
      chk("short_clr", 32'h0, rd & 32'h00FF0000);
      sclose[0] <= 1'b0;
      cy(3);
      sclose[0] <= 1'b1;
      cy(2);
      chk("red_open", 32'h3FFE, 32'(red_en));
      cy(HC - 10);
      chk("red_held", 32'h3FFE, 32'(red_en));
      cy(20);
      chk("red_back", 32'h3FFF, 32'(red_en));
      wr(PO_PER_OFS, 32'hFFFFF);
      rdc(PO_PER_OFS, "per_hi", 32'hFFFFF);
      wr(PO_PER_OFS, 32'd100);
      rdc(PO_PER_OFS, "per_lo", 32'd100);
      for (int m = 0; m < 3; m++) begin
         wr(PO_CFG_OFS, (m == 1) ? 32'h20 : ((m == 2) ? 32'h10 : 32'h0));
         wr(PO_CMD_OFS, 32'h800);
         cy(PM + 10);
         hi = 0;
         nr = 0;
         lv = (m == 1) ? low_en[0] : prim_en[NSW];
         repeat (PM) begin
            @(posedge clk);
            o = (m == 1) ? low_en[0] : prim_en[NSW];
            hi += int'(o);
            nr += int'(o & ~lv);
            lv = o;
         end
         chk("duty_hi", 32'(PM * ((m == 2) ? 4095 : 2048) / 4096), 32'(hi));
         chk("per_clamp", 32'h1, 32'(nr));
         wr(PO_CMD_OFS, 32'h0);
      end
      wr(SW_CMD_OFS, 32'h0);
      wr(PO_PER_OFS + 8'h04, 32'd100);
      wr(IMAX_OFS, 32'd100);
      po_ld[CUR_W+:CUR_W] <= 13'h00C8;
      wr(PO_CFG_OFS + 8'h04, 32'h1);
      wr(PO_CMD_OFS + 8'h04, 32'h32);
      cy(4 * PM);
      bus(1'b0, PO_STAT_OFS, 32'h0);
      chk("oc_latch", 32'h00020002, rd & 32'h00FF00FF);
      hi = 0;
      repeat (2 * PM) begin
         @(posedge clk);
         hi += int'(prim_en[NSW+1]);
      end
      chk("oc_off", 32'h0, 32'(hi));
      wr(PO_CMD_OFS + 8'h04, 32'h0);
      cy(5);
      bus(1'b0, PO_STAT_OFS, 32'h0);
      chk("oc_clr", 32'h0, rd & 32'h000000FF);
      po_short <= 8'h01;
      cy(5);
      bus(1'b0, PO_STAT_OFS, 32'h0);
      chk("po_short", 32'h00000100, rd & 32'h0000FF00);
      po_short <= 8'h00;
      wrap_up();
   end
endmodule
